// >>> logic/gdp_defines.vh
// constants for the gate driver protection configuration bank
`ifndef GDP_DEFINES_VH
`define GDP_DEFINES_VH

// register indices on the serial port (seven-bit address field)
`define GDP_ADDR_PROT_CFG     7'h04
`define GDP_ADDR_THRESH_CFG   7'h05

// reset values
`define GDP_PROT_CFG_RST      16'h0934
`define GDP_THRESH_CFG_RST    16'h7741

// protection configuration field positions
`define GDP_UV2_OFF_BIT       15
`define GDP_TSD_FILT_HI       14
`define GDP_TSD_FILT_LO       13
`define GDP_SAT_FILT_BIT      12
`define GDP_OV2_OFF_BIT       11
`define GDP_CLAMP_LOC_BIT     10
`define GDP_GM_BLANK_HI       9
`define GDP_GM_BLANK_LO       8
`define GDP_GM_OFF_BIT        7
`define GDP_MILLER_OFF_BIT    6
`define GDP_COLL_CLAMP_BIT    5
`define GDP_SAT_DET_BIT       4
`define GDP_SC_OFF_BIT        3
`define GDP_OC_OFF_BIT        2
`define GDP_TSD_ON_BIT        1
`define GDP_NEG_LOCK_BIT      0

// serial frame layout: command byte then 16 data bits
`define GDP_CMD_WRITE_BIT     7
`define GDP_FRAME_BITS        24
`define GDP_CMD_BITS          8

// clock rate and timing figures
`define GDP_CLK_MHZ           10
`define GDP_TSD_T0_NS         250
`define GDP_TSD_T1_NS         500
`define GDP_TSD_T2_NS         750
`define GDP_TSD_T3_NS         1000
`define GDP_SAT_T0_NS         158
`define GDP_SAT_T1_NS         316
`define GDP_GM_T0_NS          500
`define GDP_GM_T1_NS          1000
`define GDP_GM_T2_NS          2500
`define GDP_GM_T3_NS          4000

// least time in ns to whole clock cycles, rounded up
`define GDP_CYC_UP(ns)        ((((ns) * `GDP_CLK_MHZ) + 999) / 1000)

`endif

// >>> logic/gdp_protection_config.v
// protection configuration register bank with decoded timing counts
`timescale 1ns/100ps
`include "gdp_defines.vh"

module gdp_protection_config (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire        spi_sclk_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_mosi_i,
  output wire        spi_miso_o,
  output wire        secondary_undervoltage_off_o,
  output wire [1:0]  switch_thermal_filter_time_o,
  output wire        saturation_filter_time_o,
  output wire        secondary_overvoltage_off_o,
  output wire        clamp_location_select_o,
  output wire [1:0]  gate_monitor_blanking_o,
  output wire        gate_monitor_off_o,
  output wire        miller_clamp_off_o,
  output wire        collector_clamp_on_o,
  output wire        saturation_detect_on_o,
  output wire        short_circuit_guard_off_o,
  output wire        overcurrent_guard_off_o,
  output wire        switch_thermal_guard_on_o,
  output wire        negative_supply_lockout_on_o,
  output reg  [3:0]  thermal_filter_cycles_o,
  output reg  [2:0]  saturation_filter_cycles_o,
  output reg  [5:0]  gate_monitor_blank_cycles_o,
  output wire [15:0] fault_threshold_softoff_o
);

  // cycle counts of each selectable time at the core clock rate
  localparam integer TSD_N0 = `GDP_CYC_UP(`GDP_TSD_T0_NS);
  localparam integer TSD_N1 = `GDP_CYC_UP(`GDP_TSD_T1_NS);
  localparam integer TSD_N2 = `GDP_CYC_UP(`GDP_TSD_T2_NS);
  localparam integer TSD_N3 = `GDP_CYC_UP(`GDP_TSD_T3_NS);
  localparam integer SAT_N0 = `GDP_CYC_UP(`GDP_SAT_T0_NS);
  localparam integer SAT_N1 = `GDP_CYC_UP(`GDP_SAT_T1_NS);
  localparam integer GM_N0  = `GDP_CYC_UP(`GDP_GM_T0_NS);
  localparam integer GM_N1  = `GDP_CYC_UP(`GDP_GM_T1_NS);
  localparam integer GM_N2  = `GDP_CYC_UP(`GDP_GM_T2_NS);
  localparam integer GM_N3  = `GDP_CYC_UP(`GDP_GM_T3_NS);

  // counts cut to their output widths on purpose
  localparam [3:0] TSD_C0 = TSD_N0[3:0];
  localparam [3:0] TSD_C1 = TSD_N1[3:0];
  localparam [3:0] TSD_C2 = TSD_N2[3:0];
  localparam [3:0] TSD_C3 = TSD_N3[3:0];
  localparam [2:0] SAT_C0 = SAT_N0[2:0];
  localparam [2:0] SAT_C1 = SAT_N1[2:0];
  localparam [5:0] GM_C0  = GM_N0[5:0];
  localparam [5:0] GM_C1  = GM_N1[5:0];
  localparam [5:0] GM_C2  = GM_N2[5:0];
  localparam [5:0] GM_C3  = GM_N3[5:0];

  reg  [15:0] prot_cfg;
  reg  [15:0] thresh_cfg;
  reg  [15:0] next_prot_cfg;
  reg  [15:0] next_thresh_cfg;
  reg  [15:0] rd_data;
  reg  [3:0]  next_tsd_cycles;
  reg  [2:0]  next_sat_cycles;
  reg  [5:0]  next_gm_cycles;

  wire [6:0]  port_addr;
  wire        port_wr_stb;
  wire [15:0] port_wr_data;

  // serial host port
  gdp_spi_port u_port (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .spi_sclk_i (spi_sclk_i),
    .spi_cs_n_i (spi_cs_n_i),
    .spi_mosi_i (spi_mosi_i),
    .rd_data_i  (rd_data),
    .addr_o     (port_addr),
    .wr_stb_o   (port_wr_stb),
    .wr_data_o  (port_wr_data),
    .miso_o     (spi_miso_o)
  );

  // read mux, unmapped addresses read as zero
  always @* begin
    case (port_addr)
      `GDP_ADDR_PROT_CFG:   rd_data = prot_cfg;
      `GDP_ADDR_THRESH_CFG: rd_data = thresh_cfg;
      default:              rd_data = 16'h0000;
    endcase
  end

  // write decode, no separate commit step
  always @* begin
    next_prot_cfg   = prot_cfg;
    next_thresh_cfg = thresh_cfg;
    if (port_wr_stb) begin
      if (port_addr == `GDP_ADDR_PROT_CFG) begin
        next_prot_cfg = port_wr_data;
      end
      if (port_addr == `GDP_ADDR_THRESH_CFG) begin
        next_thresh_cfg = port_wr_data;
      end
    end
  end

  // thermal shutdown deglitch time decode
  always @* begin
    case (next_prot_cfg[`GDP_TSD_FILT_HI:`GDP_TSD_FILT_LO])
      2'h0:    next_tsd_cycles = TSD_C0;
      2'h1:    next_tsd_cycles = TSD_C1;
      2'h2:    next_tsd_cycles = TSD_C2;
      2'h3:    next_tsd_cycles = TSD_C3;
      default: next_tsd_cycles = TSD_C0;
    endcase
  end

  // saturation detector deglitch time decode
  always @* begin
    if (next_prot_cfg[`GDP_SAT_FILT_BIT]) begin
      next_sat_cycles = SAT_C1;
    end else begin
      next_sat_cycles = SAT_C0;
    end
  end

  // gate monitor blanking time decode
  always @* begin
    case (next_prot_cfg[`GDP_GM_BLANK_HI:`GDP_GM_BLANK_LO])
      2'h0:    next_gm_cycles = GM_C0;
      2'h1:    next_gm_cycles = GM_C1;
      2'h2:    next_gm_cycles = GM_C2;
      2'h3:    next_gm_cycles = GM_C3;
      default: next_gm_cycles = GM_C1;
    endcase
  end

  // register bank and decoded counts, reset to defaults
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prot_cfg                    <= `GDP_PROT_CFG_RST;
      thresh_cfg                  <= `GDP_THRESH_CFG_RST;
      thermal_filter_cycles_o     <= TSD_C0;
      saturation_filter_cycles_o  <= SAT_C0;
      gate_monitor_blank_cycles_o <= GM_C1;
    end else if (ce_i) begin
      prot_cfg                    <= next_prot_cfg;
      thresh_cfg                  <= next_thresh_cfg;
      thermal_filter_cycles_o     <= next_tsd_cycles;
      saturation_filter_cycles_o  <= next_sat_cycles;
      gate_monitor_blank_cycles_o <= next_gm_cycles;
    end
  end

  // lockout controls
  assign secondary_undervoltage_off_o = prot_cfg[`GDP_UV2_OFF_BIT];
  assign secondary_overvoltage_off_o  = prot_cfg[`GDP_OV2_OFF_BIT];
  assign negative_supply_lockout_on_o = prot_cfg[`GDP_NEG_LOCK_BIT];

  // filter and blanking selections as raw codes
  assign switch_thermal_filter_time_o =
    prot_cfg[`GDP_TSD_FILT_HI:`GDP_TSD_FILT_LO];
  assign saturation_filter_time_o     = prot_cfg[`GDP_SAT_FILT_BIT];
  assign gate_monitor_blanking_o      =
    prot_cfg[`GDP_GM_BLANK_HI:`GDP_GM_BLANK_LO];

  // clamp and monitor controls
  assign clamp_location_select_o      = prot_cfg[`GDP_CLAMP_LOC_BIT];
  assign gate_monitor_off_o           = prot_cfg[`GDP_GM_OFF_BIT];
  assign miller_clamp_off_o           = prot_cfg[`GDP_MILLER_OFF_BIT];
  assign collector_clamp_on_o         = prot_cfg[`GDP_COLL_CLAMP_BIT];
  assign saturation_detect_on_o       = prot_cfg[`GDP_SAT_DET_BIT];

  // power switch protection controls
  assign short_circuit_guard_off_o    = prot_cfg[`GDP_SC_OFF_BIT];
  assign overcurrent_guard_off_o      = prot_cfg[`GDP_OC_OFF_BIT];
  assign switch_thermal_guard_on_o    = prot_cfg[`GDP_TSD_ON_BIT];

  // second register passed on whole, meanings handled elsewhere
  assign fault_threshold_softoff_o    = thresh_cfg;

endmodule

// >>> logic/gdp_spi_port.v
// serial host port: frame shifter for register reads and writes
`timescale 1ns/100ps
`include "gdp_defines.vh"

module gdp_spi_port (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire        spi_sclk_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_mosi_i,
  input  wire [15:0] rd_data_i,
  output wire [6:0]  addr_o,
  output reg         wr_stb_o,
  output wire [15:0] wr_data_o,
  output reg         miso_o
);

  reg        sclk_q;
  reg [4:0]  bit_cnt;
  reg [23:0] rx_sr;
  reg [15:0] tx_sr;
  reg        cmd_write;
  reg [6:0]  cmd_addr;

  wire sclk_rise = spi_sclk_i & ~sclk_q;
  wire sclk_fall = ~spi_sclk_i & sclk_q;
  wire [23:0] rx_next = {rx_sr[22:0], spi_mosi_i};

  // address held from the command byte, data from the full frame
  assign addr_o    = cmd_addr; // must stand through the data phase
  assign wr_data_o = rx_sr[15:0];

  // edge tracking, shifting and frame counting
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_q    <= 1'b0;
      bit_cnt   <= 5'h00;
      rx_sr     <= 24'h000000;
      tx_sr     <= 16'h0000;
      cmd_write <= 1'b0;
      cmd_addr  <= 7'h00;
      wr_stb_o  <= 1'b0;
      miso_o    <= 1'b0;
    end else if (ce_i) begin
      sclk_q   <= spi_sclk_i;
      wr_stb_o <= 1'b0;
      if (spi_cs_n_i) begin
        // idle: next frame starts from bit zero
        bit_cnt <= 5'h00;
        miso_o  <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt < `GDP_FRAME_BITS) begin
          rx_sr   <= rx_next;
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `GDP_CMD_BITS - 1) begin
            cmd_write <= rx_next[`GDP_CMD_WRITE_BIT];
            cmd_addr  <= rx_next[6:0];
          end
          if (bit_cnt == `GDP_FRAME_BITS - 1) begin
            wr_stb_o <= cmd_write; // write lands at end of frame
          end
        end
        // read data shifts out on falling edges after the command byte
        if (sclk_fall && bit_cnt == `GDP_CMD_BITS) begin
          miso_o <= rd_data_i[15];
          tx_sr  <= {rd_data_i[14:0], 1'b0};
        end else if (sclk_fall && bit_cnt > `GDP_CMD_BITS &&
                     bit_cnt < `GDP_FRAME_BITS) begin
          miso_o <= tx_sr[15];
          tx_sr  <= {tx_sr[14:0], 1'b0};
        end
      end
    end
  end

endmodule

// >>> sim/gdp_pc_asserts.sv
// port assertions for the protection configuration bank
`timescale 1ns/100ps
module gdp_pc_asserts (
  input wire        mclk_i,
  input wire        sys_rst_i,
  input wire        ce_i,
  input wire        spi_sclk_i,
  input wire        spi_cs_n_i,
  input wire        spi_mosi_i,
  input wire        spi_miso_o,
  input wire        secondary_undervoltage_off_o,
  input wire [1:0]  switch_thermal_filter_time_o,
  input wire        saturation_filter_time_o,
  input wire        secondary_overvoltage_off_o,
  input wire        clamp_location_select_o,
  input wire [1:0]  gate_monitor_blanking_o,
  input wire        gate_monitor_off_o,
  input wire        miller_clamp_off_o,
  input wire        collector_clamp_on_o,
  input wire        saturation_detect_on_o,
  input wire        short_circuit_guard_off_o,
  input wire        overcurrent_guard_off_o,
  input wire        switch_thermal_guard_on_o,
  input wire        negative_supply_lockout_on_o,
  input wire [3:0]  thermal_filter_cycles_o,
  input wire [2:0]  saturation_filter_cycles_o,
  input wire [5:0]  gate_monitor_blank_cycles_o,
  input wire [15:0] fault_threshold_softoff_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // field outputs gathered in register order
  wire [15:0] fld = {secondary_undervoltage_off_o, switch_thermal_filter_time_o,
    saturation_filter_time_o, secondary_overvoltage_off_o, clamp_location_select_o,
    gate_monitor_blanking_o, gate_monitor_off_o, miller_clamp_off_o, collector_clamp_on_o,
    saturation_detect_on_o, short_circuit_guard_off_o, overcurrent_guard_off_o,
    switch_thermal_guard_on_o, negative_supply_lockout_on_o};
  wire [15:0] t = {12'h000, thermal_filter_cycles_o};
  property p_tsd_cyc;
    t == (switch_thermal_filter_time_o[1] ? (switch_thermal_filter_time_o[0] ? 16'h000A
      : 16'h0008) : (switch_thermal_filter_time_o[0] ? 16'h0005 : 16'h0003));
  endproperty
  a_tsd_cyc: assert property (p_tsd_cyc) else $error("thermal count wrong");
  property p_sat_cyc;
    saturation_filter_cycles_o == (saturation_filter_time_o ? 3'h4 : 3'h2);
  endproperty
  a_sat_cyc: assert property (p_sat_cyc) else $error("saturation count wrong");
  property p_gm_cyc;
    gate_monitor_blank_cycles_o == (gate_monitor_blanking_o[1] ? (gate_monitor_blanking_o[0]
      ? 6'h28 : 6'h19) : (gate_monitor_blanking_o[0] ? 6'h0A : 6'h05));
  endproperty
  a_gm_cyc: assert property (p_gm_cyc) else $error("blanking count wrong");
  property p_rst_fld;
    $fell(sys_rst_i) |-> fld == 16'h0934;
  endproperty
  a_rst_fld: assert property (p_rst_fld) else $error("field reset wrong");
  property p_rst_cnt;
    $fell(sys_rst_i) |-> {t[3:0], saturation_filter_cycles_o, gate_monitor_blank_cycles_o,
      fault_threshold_softoff_o} == {4'h3, 3'h2, 6'h0A, 16'h7741};
  endproperty
  a_rst_cnt: assert property (p_rst_cnt) else $error("count reset wrong");
  property p_ce_hold;
    !ce_i |=> $stable({fld, fault_threshold_softoff_o});
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("change while frozen");
  property p_idle_hold;
    spi_cs_n_i && $past(spi_cs_n_i) && $past(spi_cs_n_i, 2) |-> $stable(fld);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("change while idle");
  property p_chg_en;
    $changed(fld) |-> $past(ce_i) && $past(ce_i, 2);
  endproperty
  a_chg_en: assert property (p_chg_en) else $error("change without enable");
endmodule

// >>> sim/gdp_spi_host.sv
// host-side serial master model for the configuration port
`timescale 1ns/100ps
module gdp_spi_host (
  input  wire mclk_i,
  input  wire miso_i,
  output reg  sclk_o,
  output reg  cs_n_o,
  output reg  mosi_o
);
  // idle: clock parked low, chip deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // mode 0 frame, msb first, cut short after nb bits
  task automatic xfer(input logic [23:0] fr, input int nb, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    @(posedge mclk_i) #10 cs_n_o = 1'b0;
    for (i = 0; i < nb; i++) begin
      @(posedge mclk_i) #10 mosi_o = fr[23 - i];
      sclk_o = 1'b0;
      repeat (2) @(posedge mclk_i);
      #10 sclk_o = 1'b1;
      if (i >= 8) rd = {rd[14:0], miso_i};
      repeat (2) @(posedge mclk_i);
    end
    #10 sclk_o = 1'b0;
    mosi_o = ~mosi_o;  // released line shows no stale level
    repeat (3) @(posedge mclk_i);
    #10 cs_n_o = 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the protection configuration bank
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [15:0] d;
    logic [3:0]  tc;
    logic [2:0]  sc;
    logic [5:0]  gc;
  } gdp_row_t;
  logic        mclk_i;
  logic        sys_rst_i;
  logic        ce_i;
  wire         sclk;
  wire         cs_n;
  wire         mosi;
  wire         miso;
  wire  [15:0] fld;
  wire  [15:0] thr;
  wire  [3:0]  tcy;
  wire  [2:0]  scy;
  wire  [5:0]  gcy;
  logic [15:0] rd;
  int          err_total = 0;
  int          n_checks = 0;
  gdp_row_t    rows [5] = '{'{16'h0000, 4'h3, 3'h2, 6'h05}, '{16'h2100, 4'h5, 3'h2, 6'h0A},
    '{16'h5200, 4'h8, 3'h4, 6'h19}, '{16'hFFFF, 4'hA, 3'h4, 6'h28},
    '{16'hA5C3, 4'h5, 3'h2, 6'h0A}};
  gdp_spi_host u_gdp_spi_host (.mclk_i(mclk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi));
  gdp_protection_config u_gdp_protection_config (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .secondary_undervoltage_off_o(fld[15]), .switch_thermal_filter_time_o(fld[14:13]),
    .saturation_filter_time_o(fld[12]), .secondary_overvoltage_off_o(fld[11]),
    .clamp_location_select_o(fld[10]), .gate_monitor_blanking_o(fld[9:8]),
    .gate_monitor_off_o(fld[7]), .miller_clamp_off_o(fld[6]), .collector_clamp_on_o(fld[5]),
    .saturation_detect_on_o(fld[4]), .short_circuit_guard_off_o(fld[3]),
    .overcurrent_guard_off_o(fld[2]), .switch_thermal_guard_on_o(fld[1]),
    .negative_supply_lockout_on_o(fld[0]), .thermal_filter_cycles_o(tcy),
    .saturation_filter_cycles_o(scy), .gate_monitor_blank_cycles_o(gcy),
    .fault_threshold_softoff_o(thr));
  // compare one value, count and report
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_gdp_spi_host.xfer({1'b1, a, d}, 24, rd);
  endtask
  task automatic rdr(input logic [6:0] a);
    u_gdp_spi_host.xfer({1'b0, a, 16'h0000}, 24, rd);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // 10 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // watchdog well past the expected run
  initial begin
    #1000000;
    err_total++;
    final_report();
  end
  // table of writes, then awkward cases, then mid-run reset
  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #10 sys_rst_i = 1'b0;
    foreach (rows[i]) begin
      wr(7'h04, rows[i].d);
      chk("fields", rows[i].d, fld);
      chk("cycles", {3'h0, rows[i].tc, rows[i].sc, rows[i].gc}, {3'h0, tcy, scy, gcy});
      rdr(7'h04);
      chk("readback", rows[i].d, rd);
    end
    $display("test table done");
    wr(7'h05, 16'h1234);
    rdr(7'h05);
    chk("second reg", 16'h1234, thr);
    chk("second readback", 16'h1234, rd);
    wr(7'h06, 16'h0000);
    rdr(7'h06);
    chk("unmapped read", 16'h0000, rd);
    chk("unmapped write", rows[4].d, fld);
    u_gdp_spi_host.xfer({8'h84, 16'h0000}, 20, rd);
    chk("partial frame", rows[4].d, fld);
    @(posedge mclk_i) #10 ce_i = 1'b0;
    wr(7'h04, 16'h0000);
    chk("frozen", rows[4].d, fld);
    @(posedge mclk_i) #10 ce_i = 1'b1;
    $display("test awkward done");
    @(posedge mclk_i) #10 sys_rst_i = 1'b1;
    @(posedge mclk_i) #10 chk("reset fields", 16'h0934, fld);
    chk("reset cycles", {3'h0, 4'h3, 3'h2, 6'h0A}, {3'h0, tcy, scy, gcy});
    chk("reset second", 16'h7741, thr);
    sys_rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    wr(7'h04, 16'h8000);
    chk("write after reset", 16'h8000, fld);
    rdr(7'h05);
    chk("second reset readback", 16'h7741, rd);
    $display("test reset done");
    final_report();
  end
endmodule
bind gdp_protection_config gdp_pc_asserts u_gdp_pc_asserts (.*);
